// ---- hw/gsb_pkg.sv ----
// constants for the global status and boot flag register block
package gsb_pkg;
	localparam int           ADDR_W            = 16;
	localparam int           DATA_W            = 8;
	localparam int           GPIO_N            = 4;
	localparam logic [15:0]  OFS_GP_INPUT      = 16'h0219;
	localparam logic [15:0]  OFS_IRQ_SUMMARY   = 16'h021A;
	localparam logic [15:0]  OFS_RSVD_1        = 16'h021B;
	localparam logic [15:0]  OFS_RSVD_2        = 16'h021C;
	localparam logic [15:0]  OFS_RSVD_3        = 16'h021D;
	localparam logic [15:0]  OFS_BOOT_FAIL     = 16'h021E;
	localparam logic [15:0]  OFS_EEPROM_STATUS = 16'h021F;
	localparam int           BIT_IRQ           = 0;
	localparam int           BIT_LOAD_FAILED   = 0;
	localparam int           BIT_LOAD_COMPLETE = 0;
	localparam int           BIT_CHECKSUM_OK   = 3;
	localparam logic [7:0]   RSVD_READ         = 8'h00;
	localparam logic         RST_LOAD_FAILED   = 1'b0;
	localparam logic         RST_LOAD_COMPLETE = 1'b0;
	localparam logic         RST_CHECKSUM_OK   = 1'b1;
endpackage

// ---- hw/gsb_sync.sv ----
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
module gsb_sync #(
	parameter int W = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} gsb_sync_st_t;

	gsb_sync_st_t st_r;
	gsb_sync_st_t st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.meta = i_async;
		st_nxt.sync = st_r.meta;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_sync = st_r.sync;
endmodule

// ---- hw/gsb_status_regs.sv ----
// global status and boot flag registers with interrupt summary pin
// Notes on behaviour
// - the input level field returns the two-flop synchronised level of each pin configured as input, one bit each.
// - the summary flag and the low interrupt pin are active while an enabled status bit is set, registered one cycle later.
// - the load failed flag sets when the eeprom read fails and holds until reset.
// - the load complete flag sets when the eeprom read cycle ends and holds until reset.
// - the checksum ok bit holds 0 after an eeprom crc failure and 1 otherwise.
// - after a checksum failure the host port refuses all accesses until reset.
`timescale 1ns/1ns
module gsb_status_regs (
	input  wire logic                         i_clk,
	input  wire logic                         i_rst_n,
	input  wire logic [gsb_pkg::GPIO_N-1:0]   i_gpio_pin,
	input  wire logic [gsb_pkg::GPIO_N-1:0]   i_gpio_is_input,
	input  wire logic                         i_irq_any_enabled,
	input  wire logic                         i_eeprom_fail,
	input  wire logic                         i_eeprom_done,
	input  wire logic                         i_eeprom_crc_err,
	input  wire logic                         i_host_req,
	input  wire logic                         i_host_wr,
	input  wire logic [gsb_pkg::ADDR_W-1:0]   i_host_addr,
	input  wire logic [gsb_pkg::DATA_W-1:0]   i_host_wdata,
	output logic                              o_host_ack,
	output logic      [gsb_pkg::DATA_W-1:0]   o_host_rdata,
	output logic                              o_host_locked,
	output logic                              o_irq_out_low
);
	typedef struct packed {
		logic                       eeprom_load_failed;
		logic                       eeprom_load_complete;
		logic                       eeprom_checksum_ok;
		logic                       host_locked;
		logic                       irq_summary;
		logic                       ack;
		logic [gsb_pkg::DATA_W-1:0] rdata;
	} gsb_state_t;

	gsb_state_t st_r;
	gsb_state_t st_nxt;

	logic                       rst_n;
	logic [gsb_pkg::GPIO_N-1:0] gpio_sync;
	logic [gsb_pkg::DATA_W-1:0] rd_val;
	logic                       accept;

	// reset release through two flops; assertion is still asynchronous
	logic [1:0] rst_pipe_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_r[1];

	gsb_sync #(
		.W(gsb_pkg::GPIO_N)
	) gsb_sync_i (
		.i_clk  (i_clk),
		.i_rst_n(rst_n),
		.i_async(i_gpio_pin),
		.o_sync (gpio_sync)
	);

	// port is refused once the crc check has failed
	assign accept = i_host_req && !st_r.host_locked;

	always_comb begin
		rd_val = gsb_pkg::RSVD_READ;
		unique case (i_host_addr)
			gsb_pkg::OFS_GP_INPUT: begin
				rd_val[gsb_pkg::GPIO_N-1:0] = gpio_sync & i_gpio_is_input;
			end
			gsb_pkg::OFS_IRQ_SUMMARY: begin
				rd_val[gsb_pkg::BIT_IRQ] = st_r.irq_summary;
			end
			gsb_pkg::OFS_BOOT_FAIL: begin
				rd_val[gsb_pkg::BIT_LOAD_FAILED] = st_r.eeprom_load_failed;
			end
			gsb_pkg::OFS_EEPROM_STATUS: begin
				rd_val[gsb_pkg::BIT_LOAD_COMPLETE] = st_r.eeprom_load_complete;
				rd_val[gsb_pkg::BIT_CHECKSUM_OK]   = st_r.eeprom_checksum_ok;
			end
			default: begin
				rd_val = gsb_pkg::RSVD_READ;
			end
		endcase
	end

	always_comb begin
		st_nxt          = st_r;
		st_nxt.ack      = accept;
		// writes are acknowledged but touch no status field
		if (accept && !i_host_wr) begin
			st_nxt.rdata = rd_val;
		end
		st_nxt.irq_summary = i_irq_any_enabled;
		if (i_eeprom_fail) begin
			st_nxt.eeprom_load_failed = 1'b1;
		end
		if (i_eeprom_done) begin
			st_nxt.eeprom_load_complete = 1'b1;
		end
		if (i_eeprom_crc_err) begin
			st_nxt.eeprom_checksum_ok = 1'b0;
			st_nxt.host_locked        = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r                      <= '0;
			st_r.eeprom_load_failed   <= gsb_pkg::RST_LOAD_FAILED;
			st_r.eeprom_load_complete <= gsb_pkg::RST_LOAD_COMPLETE;
			st_r.eeprom_checksum_ok   <= gsb_pkg::RST_CHECKSUM_OK;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_host_ack    = st_r.ack;
	assign o_host_rdata  = st_r.rdata;
	assign o_host_locked = st_r.host_locked;
	assign o_irq_out_low = !st_r.irq_summary;

	property p_irq_follows;
		@(posedge i_clk) disable iff (!rst_n)
		i_irq_any_enabled |=> (st_r.irq_summary && !o_irq_out_low);
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("irq pin not asserted");

	property p_irq_release;
		@(posedge i_clk) disable iff (!rst_n)
		!i_irq_any_enabled |=> o_irq_out_low;
	endproperty
	a_irq_release: assert property (p_irq_release) else $error("irq pin not released");

	property p_fail_sticky;
		@(posedge i_clk) disable iff (!rst_n)
		i_eeprom_fail |=> st_r.eeprom_load_failed [*8];
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("load failed flag lost");

	property p_done_sticky;
		@(posedge i_clk) disable iff (!rst_n)
		st_r.eeprom_load_complete |=> st_r.eeprom_load_complete;
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("load complete flag lost");

	property p_done_set;
		@(posedge i_clk) disable iff (!rst_n)
		i_eeprom_done |=> st_r.eeprom_load_complete;
	endproperty
	a_done_set: assert property (p_done_set) else $error("load complete not set");

	property p_crc_bit;
		@(posedge i_clk) disable iff (!rst_n)
		i_eeprom_crc_err |=> (!st_r.eeprom_checksum_ok && o_host_locked);
	endproperty
	a_crc_bit: assert property (p_crc_bit) else $error("crc error not reported");

	property p_locked_no_ack;
		@(posedge i_clk) disable iff (!rst_n)
		o_host_locked |=> !o_host_ack;
	endproperty
	a_locked_no_ack: assert property (p_locked_no_ack) else $error("locked port answered");

	property p_write_no_effect;
		@(posedge i_clk) disable iff (!rst_n)
		(i_host_req && i_host_wr && !i_eeprom_fail && !i_eeprom_done && !i_eeprom_crc_err)
			|=> ($stable(st_r.eeprom_load_failed) && $stable(st_r.eeprom_load_complete)
			&& $stable(st_r.eeprom_checksum_ok));
	endproperty
	a_write_no_effect: assert property (p_write_no_effect) else $error("write changed status");

	property p_read_ack;
		@(posedge i_clk) disable iff (!rst_n)
		(i_host_req && !o_host_locked) |=> o_host_ack;
	endproperty
	a_read_ack: assert property (p_read_ack) else $error("access not answered");

	property p_locked_hold;
		@(posedge i_clk) disable iff (!rst_n)
		o_host_locked |=> o_host_locked;
	endproperty
	a_locked_hold: assert property (p_locked_hold) else $error("port lock lost");

	property p_crc_hold;
		@(posedge i_clk) disable iff (!rst_n)
		!st_r.eeprom_checksum_ok |=> !st_r.eeprom_checksum_ok;
	endproperty
	a_crc_hold: assert property (p_crc_hold) else $error("checksum error lost");

	property p_fail_hold;
		@(posedge i_clk) disable iff (!rst_n)
		st_r.eeprom_load_failed |=> st_r.eeprom_load_failed;
	endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("load failed flag dropped");

	// pins not configured as inputs must never leak into the read byte
	property p_gpio_mask;
		@(posedge i_clk) disable iff (!rst_n)
		(accept && !i_host_wr && (i_host_addr == gsb_pkg::OFS_GP_INPUT))
			|=> ((o_host_rdata & ~{4'h0, $past(i_gpio_is_input)}) == 8'h00);
	endproperty
	a_gpio_mask: assert property (p_gpio_mask) else $error("non input pin level read");

	property p_rsvd_read;
		@(posedge i_clk) disable iff (!rst_n)
		(accept && !i_host_wr && (i_host_addr == gsb_pkg::OFS_RSVD_1))
			|=> (o_host_rdata == gsb_pkg::RSVD_READ);
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte not zero");

	property p_wr_rdata;
		@(posedge i_clk) disable iff (!rst_n)
		(accept && i_host_wr) |=> $stable(o_host_rdata);
	endproperty
	a_wr_rdata: assert property (p_wr_rdata) else $error("write changed read data");

	c_crc_lock: cover property (@(posedge i_clk) disable iff (!rst_n)
		i_eeprom_crc_err ##[1:8] (i_host_req && o_host_locked));
	c_boot_done: cover property (@(posedge i_clk) disable iff (!rst_n)
		i_eeprom_done ##[1:8] o_host_ack);
	c_gpio_read: cover property (@(posedge i_clk) disable iff (!rst_n)
		(accept && (i_host_addr == gsb_pkg::OFS_GP_INPUT)) ##1 o_host_ack);
	c_wr_ack: cover property (@(posedge i_clk) disable iff (!rst_n)
		(accept && i_host_wr) ##1 o_host_ack);
	c_irq_pulse: cover property (@(posedge i_clk) disable iff (!rst_n)
		!o_irq_out_low ##1 o_irq_out_low);
endmodule

// ---- tb/gsb_eeprom_model.sv ----
// eeprom partner: reports the load outcome a few cycles after start
`timescale 1ns/1ns
module gsb_eeprom_model (
	input  wire logic       i_clk,
	input  wire logic       i_start,
	input  wire logic [1:0] i_mode,
	output logic            o_done,
	output logic            o_fail,
	output logic            o_crc_err
);
	logic [1:0] cnt_r = 2'h0;
	initial {o_done, o_fail, o_crc_err} = 3'h0;
	// mode 0 good load, 1 read failure, 2 crc failure; one-cycle pulses
	always @(posedge i_clk) begin
		o_done    <= (cnt_r == 2'h1);
		o_fail    <= (cnt_r == 2'h1) && (i_mode == 2'h1);
		o_crc_err <= (cnt_r == 2'h1) && (i_mode == 2'h2);
		cnt_r     <= i_start ? 2'h3 : ((cnt_r != 2'h0) ? cnt_r - 2'h1 : 2'h0);
	end
endmodule

// ---- tb/gsb_status_regs_tb_top.sv ----
// self-checking bench for the status and boot flag registers
`timescale 1ns/1ns
module gsb_status_regs_tb_top;
	logic        i_clk = 0, i_rst_n = 0, i_irq_any_enabled = 0;
	logic        i_host_req = 0, i_host_wr = 0, start = 0;
	logic [3:0]  i_gpio_pin = 0, i_gpio_is_input = 0;
	logic [1:0]  mode = 0;
	logic [15:0] i_host_addr = 0;
	logic [7:0]  i_host_wdata = 0, o_host_rdata;
	logic        o_host_ack, o_host_locked, o_irq_out_low;
	logic        i_eeprom_fail, i_eeprom_done, i_eeprom_crc_err;
	int          n_mismatch = 0, num_checks = 0, cyc = 0;
	gsb_status_regs gsb_status_regs_i (.i_clk, .i_rst_n, .i_gpio_pin, .i_gpio_is_input,
		.i_irq_any_enabled, .i_eeprom_fail, .i_eeprom_done, .i_eeprom_crc_err,
		.i_host_req, .i_host_wr, .i_host_addr, .i_host_wdata, .o_host_ack,
		.o_host_rdata, .o_host_locked, .o_irq_out_low);
	gsb_eeprom_model gsb_eeprom_model_i (.i_clk, .i_start(start), .i_mode(mode),
		.o_done(i_eeprom_done), .o_fail(i_eeprom_fail), .o_crc_err(i_eeprom_crc_err));
	initial forever #4 i_clk = ~i_clk;
	// whole run needs well under 1000 cycles
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			print_verdict;
		end
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clk);
		{i_host_req, i_host_wr, i_host_addr, i_host_wdata} = {1'b1, w, a, d};
		@(negedge i_clk);
		{i_host_req, i_host_wr, i_host_wdata} = 10'h000;
	endtask
	// ack and data are both registered on the taking edge and checked at the next falling edge
	task rd(input logic [15:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(8'h01, {7'h00, o_host_ack});
		chk(e, o_host_rdata);
	endtask
	task do_reset;
		i_rst_n = 0;
		repeat (20) @(negedge i_clk);
		i_rst_n = 1;
		repeat (4) @(negedge i_clk);
	endtask
	task load(input logic [1:0] m);
		@(negedge i_clk);
		{start, mode} = {1'b1, m};
		@(negedge i_clk);
		start = 0;
		repeat (6) @(negedge i_clk);
	endtask
	task t_idle;
		rd(16'h021F, 8'h08);
		rd(16'h021E, 8'h00);
		rd(16'h021A, 8'h00);
		rd(16'h0300, 8'h00);
		rd(16'h021B, 8'h00);
		$display("test idle done");
	endtask
	task t_gpio;
		{i_gpio_pin, i_gpio_is_input} = 8'hA6;
		repeat (4) @(negedge i_clk);
		rd(16'h0219, 8'h02);
		{i_gpio_pin, i_gpio_is_input} = 8'h5F;
		repeat (4) @(negedge i_clk);
		rd(16'h0219, 8'h05);
		$display("test gpio done");
	endtask
	task t_irq;
		i_irq_any_enabled = 1;
		repeat (2) @(negedge i_clk);
		chk(8'h00, {7'h00, o_irq_out_low});
		rd(16'h021A, 8'h01);
		i_irq_any_enabled = 0;
		repeat (2) @(negedge i_clk);
		chk(8'h01, {7'h00, o_irq_out_low});
		$display("test irq done");
	endtask
	task t_boot_fail;
		i_irq_any_enabled = 1;
		load(2'h1);
		acc(1'b1, 16'h021E, 8'h00);
		acc(1'b1, 16'h021A, 8'h00);
		acc(1'b1, 16'h021B, 8'h00);
		chk(8'h01, {7'h00, o_host_ack});
		rd(16'h021E, 8'h01);
		rd(16'h021F, 8'h09);
		rd(16'h021A, 8'h01);
		chk(8'h00, {7'h00, o_irq_out_low});
		i_irq_any_enabled = 0;
		$display("test boot fail done");
	endtask
	task t_crc_lock;
		// port locks with the crc error, so the checksum bit is only visible inside
		load(2'h2);
		chk(8'h01, {7'h00, o_host_locked});
		chk(8'h00, {7'h00, gsb_status_regs_i.st_r.eeprom_checksum_ok});
		acc(1'b0, 16'h021F, 8'h00);
		chk(8'h00, {7'h00, o_host_ack});
		chk(8'h00, o_host_rdata);
		do_reset;
		chk(8'h00, {7'h00, o_host_locked});
		rd(16'h021F, 8'h08);
		rd(16'h021E, 8'h00);
		$display("test crc lock done");
	endtask
	initial begin
		do_reset;
		t_idle;
		t_gpio;
		t_irq;
		t_boot_fail;
		do_reset;
		t_crc_lock;
		print_verdict;
	end
endmodule
